// >>> verilog/dbsram_ctl.sv
// Purpose: controller end: makes link clocks and runs two-word bursts
// Assumes: one request at a time, taken when READY_O high
// Notes: read words captured on valid flag with echo rises
`timescale 1ns/1ps
`default_nettype none
module dbsram_ctl
	import dbsram_pkg::*;
(
	input  wire logic              SYS_CLK_I,
	input  wire logic              RESETN_I,
	input  wire logic              REQ_I,
	input  wire logic              WRITE_I,
	input  wire logic [ADDR_W-1:0] ADDR_I,
	input  wire logic [DATA_W-1:0] WDATA0_I,
	input  wire logic [DATA_W-1:0] WDATA1_I,
	input  wire logic [LANES-1:0]  WSEL0_N_I,
	input  wire logic [LANES-1:0]  WSEL1_N_I,
	input  wire logic              PLL_ON_I,
	output logic                   READY_O,
	output logic [DATA_W-1:0]      RDATA0_O,
	output logic [DATA_W-1:0]      RDATA1_O,
	output logic                   RVALID_O,
	dbsram_if.ctl                  LINK
);
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_LOAD = 2'b01, ST_DATA = 2'b10, ST_WAIT = 2'b11} dbsram_st_type;
	// ==========================================================
	// link clock divider: phase counter over one full period
	logic [3:0] ph_ff;
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) ph_ff <= 4'h0;
		else ph_ff <= (ph_ff == 4'(2*LINK_HALF-1)) ? 4'h0 : ph_ff + 4'h1;
	end
	wire k_hi     = ph_ff < 4'(LINK_HALF);
	wire pos_next = ph_ff == 4'(2*LINK_HALF-1); // positive rise on next edge
	wire neg_next = ph_ff == 4'(LINK_HALF-1);

	dbsram_st_type st_ff;
	logic              load_n_ff;
	logic              rw_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [DATA_W-1:0] wd_ff;
	logic [LANES-1:0]  sel_ff;
	logic              oe_ff;
	logic [DATA_W-1:0] wd1_ff;
	logic [LANES-1:0]  sel1_ff;
	logic              beat_ff;
	logic [DATA_W-1:0] r0_ff;
	logic [DATA_W-1:0] r1_ff;
	logic              rv_ff;
	logic              pll_ff;

	// echo rises seen through synchronisers
	logic e_rise;
	logic en_rise;
	logic v_lvl;
	dbsram_edge u_e  (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .SIG_I(LINK.echo_clock_out),
		.LEVEL_O(), .RISE_O(e_rise));
	dbsram_edge u_en (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .SIG_I(LINK.echo_clock_out_n),
		.LEVEL_O(), .RISE_O(en_rise));
	dbsram_edge u_v  (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .SIG_I(LINK.output_valid_flag),
		.LEVEL_O(v_lvl), .RISE_O());
	logic [DATA_W-1:0] dq_meta_ff;
	logic [DATA_W-1:0] dq_sync_ff;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			st_ff <= ST_IDLE;
			load_n_ff <= 1'b1;
			rw_ff <= 1'b1;
			addr_ff <= '0;
			wd_ff <= DATA_RST;
			sel_ff <= '1;
			oe_ff <= 1'b0;
			wd1_ff <= DATA_RST;
			sel1_ff <= '1;
			beat_ff <= 1'b0;
			r0_ff <= DATA_RST;
			r1_ff <= DATA_RST;
			rv_ff <= 1'b0;
			pll_ff <= 1'b1;
			dq_meta_ff <= DATA_RST;
			dq_sync_ff <= DATA_RST;
		end else begin
			dq_meta_ff <= LINK.dq;
			dq_sync_ff <= dq_meta_ff;
			rv_ff <= 1'b0;
			case (st_ff)
				ST_IDLE: begin
					if (REQ_I && pos_next) begin
						load_n_ff <= 1'b0;
						rw_ff     <= ~WRITE_I;
						addr_ff   <= ADDR_I;
						wd_ff     <= WDATA0_I;
						sel_ff    <= WSEL0_N_I;
						wd1_ff    <= WDATA1_I;
						sel1_ff   <= WSEL1_N_I;
						pll_ff    <= PLL_ON_I;
						st_ff     <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					if (pos_next) begin
						load_n_ff <= 1'b1;
						if (!rw_ff) begin
							oe_ff <= 1'b1; // first beat with its selects
							st_ff <= ST_DATA;
						end else begin
							beat_ff <= 1'b0;
							st_ff <= ST_WAIT;
						end
					end
				end
				ST_DATA: begin
					if (neg_next) begin
						wd_ff  <= wd1_ff; // second beat
						sel_ff <= sel1_ff;
					end else if (pos_next) begin
						oe_ff  <= 1'b0;
						sel_ff <= '1;
						st_ff  <= ST_IDLE;
					end
				end
				ST_WAIT: begin
					if (v_lvl && e_rise && !beat_ff) begin
						r0_ff   <= dq_sync_ff;
						beat_ff <= 1'b1;
					end else if (beat_ff && en_rise) begin
						r1_ff   <= dq_sync_ff;
						rv_ff   <= 1'b1;
						beat_ff <= 1'b0;
						st_ff   <= ST_IDLE;
					end
				end
				default: st_ff <= ST_IDLE;
			endcase
		end
	end

	assign LINK.link_clk         = k_hi;
	assign LINK.link_clk_n       = ~k_hi;
	assign LINK.cycle_load_n     = load_n_ff;
	assign LINK.rd_wr            = rw_ff;
	assign LINK.addr             = addr_ff;
	assign LINK.byte_write_sel_n = sel_ff;
	assign LINK.dq_ctl           = wd_ff;
	assign LINK.dq_ctl_oe        = oe_ff;
	assign LINK.pll_disable_n    = pll_ff;
	assign READY_O  = (st_ff == ST_IDLE);
	assign RDATA0_O = r0_ff;
	assign RDATA1_O = r1_ff;
	assign RVALID_O = rv_ff;
endmodule // dbsram_ctl
`default_nettype wire

// >>> verilog/dbsram_pkg.sv
// Purpose: shared constants for the double-rate burst sram port and its controller
// Assumes: 18-bit word variant, depth scaled down for simulation
// Notes: link clock halves are sampled by the system clock
`default_nettype none
package dbsram_pkg;
	localparam int DATA_W    = 18;
	localparam int LANE_W    = 9;
	localparam int LANES     = DATA_W / LANE_W;
	localparam int ADDR_W    = 6;
	localparam int DEPTH     = 1 << ADDR_W;
	localparam int BURST_LEN = 2;
	// link clock half period in system clocks
	localparam int LINK_HALF = 4;
	localparam int LAT_PLL   = 2;
	localparam int LAT_DDR1  = 1;
	localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
	function automatic logic [DATA_W-1:0] dbsram_merge(input logic [DATA_W-1:0] old_w,
		input logic [DATA_W-1:0] new_w, input logic [LANES-1:0] sel_n);
		logic [DATA_W-1:0] res;
		res = old_w;
		for (int i = 0; i < LANES; i++) begin
			if (!sel_n[i]) begin
				res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
			end
		end
		return res;
	endfunction
endpackage
`default_nettype wire

// >>> verilog/dbsram_if.sv
// Purpose: pin bundle between the sram port and its controller
// Assumes: data bus resolved from the two enables
// Notes: no clocking block
`timescale 1ns/1ps
`default_nettype none
interface dbsram_if;
	import dbsram_pkg::*;
	logic                 link_clk;
	logic                 link_clk_n;
	logic                 cycle_load_n;
	logic                 rd_wr;
	logic [ADDR_W-1:0]    addr;
	logic [LANES-1:0]     byte_write_sel_n;
	logic [DATA_W-1:0]    dq_ctl;
	logic                 dq_ctl_oe;
	logic [DATA_W-1:0]    dq_dev;
	logic                 dq_dev_oe;
	logic [DATA_W-1:0]    dq;
	logic                 echo_clock_out;
	logic                 echo_clock_out_n;
	logic                 output_valid_flag;
	logic                 pll_disable_n;
	// the wire level: whichever end drives it, else all ones as a weak pull
	assign dq = dq_dev_oe ? dq_dev : (dq_ctl_oe ? dq_ctl : {DATA_W{1'b1}});
	modport dev (input link_clk, link_clk_n, cycle_load_n, rd_wr, addr, byte_write_sel_n, dq, pll_disable_n,
		output dq_dev, dq_dev_oe, echo_clock_out, echo_clock_out_n, output_valid_flag);
	modport ctl (output link_clk, link_clk_n, cycle_load_n, rd_wr, addr, byte_write_sel_n, dq_ctl, dq_ctl_oe,
		pll_disable_n, input dq, echo_clock_out, echo_clock_out_n, output_valid_flag);
endinterface
`default_nettype wire

// >>> verilog/dbsram_edge.sv
// Purpose: two-flop synchroniser with rising edge detect
// Assumes: input from another clock domain
// Notes: the first flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module dbsram_edge (
	input  wire logic SYS_CLK_I,
	input  wire logic RESETN_I,
	input  wire logic SIG_I,
	output logic      LEVEL_O,
	output logic      RISE_O
);
	logic meta_ff;
	logic sync_ff;
	logic last_ff;
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			last_ff <= 1'b0;
		end else begin
			meta_ff <= SIG_I;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end
	assign LEVEL_O = sync_ff;
	assign RISE_O  = sync_ff & ~last_ff;
endmodule // dbsram_edge
`default_nettype wire

// >>> verilog/dbsram_dev.sv
// Purpose: device end of the double-rate two-word burst sram port
// Assumes: link clocks come from the controller, sampled on SYS_CLK_I
// Notes: latency counted in positive link clock edges
// How it works
// - write beats captured on both clock rises
// - read beats driven on both clock rises
// - bus released on the positive rise after the second read beat
// - low load on positive edge starts cycle
// - every access moves exactly two words
// - each select gates one byte lane
// - deselected byte keeps its stored value
// - selects sampled with their data beat
// - one address bus for reads and writes
// - direction high reads, low writes
// - valid flag marks read data, echo aligned
// - storage split into two word arrays
// - pll on: two cycle read latency
// - pll off: one cycle read latency
// - controls registered on positive edge only
`timescale 1ns/1ps
`default_nettype none
module dbsram_dev
	import dbsram_pkg::*;
(
	input  wire logic SYS_CLK_I,
	input  wire logic RESETN_I,
	dbsram_if.dev     LINK
);
	// ==========================================================
	// link clock edges
	logic kp_rise;
	logic kn_rise;
	logic kp_lvl;
	logic kn_lvl;
	dbsram_edge u_kp (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .SIG_I(LINK.link_clk),
		.LEVEL_O(kp_lvl), .RISE_O(kp_rise));
	dbsram_edge u_kn (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .SIG_I(LINK.link_clk_n),
		.LEVEL_O(kn_lvl), .RISE_O(kn_rise));

	// inputs delayed by the same two flops so they line up with the sampled edges
	localparam int IN_W = 1 + 1 + ADDR_W + LANES + DATA_W + 1;
	logic [IN_W-1:0] in_meta_ff;
	logic [IN_W-1:0] in_sync_ff;
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			in_meta_ff <= '0;
			in_sync_ff <= '0;
		end else begin
			in_meta_ff <= {LINK.cycle_load_n, LINK.rd_wr, LINK.addr, LINK.byte_write_sel_n, LINK.dq,
				LINK.pll_disable_n};
			in_sync_ff <= in_meta_ff;
		end
	end
	wire               s_load_n = in_sync_ff[IN_W-1];
	wire               s_rd     = in_sync_ff[IN_W-2];
	wire [ADDR_W-1:0]  s_addr   = in_sync_ff[IN_W-3 -: ADDR_W];
	wire [LANES-1:0]   s_sel_n  = in_sync_ff[DATA_W+LANES : DATA_W+1];
	wire [DATA_W-1:0]  s_dq     = in_sync_ff[DATA_W:1];
	wire               s_pll    = in_sync_ff[0];

	// ==========================================================
	// storage: one array per burst word
	logic [DATA_W-1:0] mem0 [DEPTH];
	logic [DATA_W-1:0] mem1 [DEPTH];

	// ==========================================================
	// command capture
	logic              wr_pend_ff;
	logic              wr_beat_ff;
	logic [ADDR_W-1:0] wr_addr_ff;
	logic [ADDR_W-1:0] rd_addr_ff;
	logic [1:0]        rd_wait_ff;
	logic              rd_busy_ff;
	logic              rd_beat_ff;
	logic [DATA_W-1:0] dq_out_ff;
	logic              oe_ff;

	wire start_rd = kp_rise & ~s_load_n & s_rd;
	wire start_wr = kp_rise & ~s_load_n & ~s_rd;
	wire [1:0] lat = s_pll ? 2'(LAT_PLL) : 2'(LAT_DDR1);
	// write beats follow the load: first on the positive rise, second on the negative one
	wire wr_beat0 = wr_pend_ff & kp_rise & ~wr_beat_ff;
	wire wr_beat1 = wr_pend_ff & kn_rise & wr_beat_ff;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			wr_pend_ff <= 1'b0;
			wr_beat_ff <= 1'b0;
			wr_addr_ff <= '0;
		end else begin
			if (start_wr) begin
				wr_pend_ff <= 1'b1;
				wr_beat_ff <= 1'b0;
				wr_addr_ff <= s_addr;
			end else if (wr_beat0) begin
				wr_beat_ff <= 1'b1;
			end else if (wr_beat1) begin
				wr_pend_ff <= 1'b0;
				wr_beat_ff <= 1'b0;
			end
		end
	end

	// first data beat of a write lands one positive edge after the load, the second on the negative rise after it
	always_ff @(posedge SYS_CLK_I) begin
		if (wr_beat0 && !start_wr) begin
			mem0[wr_addr_ff] <= dbsram_merge(mem0[wr_addr_ff], s_dq, s_sel_n);
		end
		if (wr_beat1) begin
			mem1[wr_addr_ff] <= dbsram_merge(mem1[wr_addr_ff], s_dq, s_sel_n);
		end
	end

	// ==========================================================
	// read pipeline
	// a read counts positive rises down from its latency; the word is driven on the last one
	wire rd_tick    = rd_busy_ff & kp_rise;
	wire rd_launch  = rd_tick & (rd_wait_ff == 2'h1);
	wire rd_count   = rd_tick & (rd_wait_ff != 2'h1);
	wire rd_second  = rd_beat_ff & kn_rise;
	// release only on a positive rise that launches nothing new
	wire rd_release = ~rd_beat_ff & oe_ff & kp_rise & ~rd_launch;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rd_wait_ff <= 2'h0;
			rd_busy_ff <= 1'b0;
			rd_beat_ff <= 1'b0;
			rd_addr_ff <= '0;
			dq_out_ff  <= DATA_RST;
			oe_ff      <= 1'b0;
		end else begin
			if (start_rd) begin
				rd_addr_ff <= s_addr;
				rd_wait_ff <= lat;
				rd_busy_ff <= 1'b1;
			end else if (rd_launch) begin
				dq_out_ff  <= mem0[rd_addr_ff];
				oe_ff      <= 1'b1;
				rd_beat_ff <= 1'b1;
				rd_busy_ff <= 1'b0;
				rd_wait_ff <= 2'h0;
			end else if (rd_count) begin
				rd_wait_ff <= rd_wait_ff - 2'h1;
			end
			if (rd_second) begin
				dq_out_ff  <= mem1[rd_addr_ff];
				rd_beat_ff <= 1'b0;
			end else if (rd_release) begin
				oe_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// echo clocks
	// the sampled link clocks are delayed one more flop so that their edges
	// land on the same system clock edge as the registered data and valid flag;
	// without it the far end would see the echo rise one cycle before the data
	logic echo_ff;
	logic echo_n_ff;
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			echo_ff   <= 1'b0;
			echo_n_ff <= 1'b0;
		end else begin
			echo_ff   <= kp_lvl;
			echo_n_ff <= kn_lvl;
		end
	end

	assign LINK.dq_dev            = dq_out_ff;
	assign LINK.dq_dev_oe         = oe_ff;
	assign LINK.output_valid_flag = oe_ff;
	assign LINK.echo_clock_out    = echo_ff;
	assign LINK.echo_clock_out_n  = echo_n_ff;
endmodule // dbsram_dev
`default_nettype wire

// >>> test/dbsram_properties.sv
// Purpose: link assertions between the sram port and its controller
// Assumes: one system clock samples every link signal
// Notes: windows leave room for the 2-3 clock synchroniser lag
`timescale 1ns/1ps
`default_nettype none
module dbsram_properties (
	input wire logic SYS_CLK_I,
	input wire logic RESETN_I,
	input wire logic link_clk,
	input wire logic link_clk_n,
	input wire logic cycle_load_n,
	input wire logic rd_wr,
	input wire logic dq_ctl_oe,
	input wire logic dq_dev_oe,
	input wire logic echo_clock_out,
	input wire logic output_valid_flag,
	input wire logic pll_disable_n
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESETN_I);
	// ==========================================
	// assertions
	a_clock_pair: assert property (link_clk_n != link_clk)
		else $error("link clocks not complementary");
	a_clock_period: assert property ($rose(link_clk) |-> ##8 $rose(link_clk))
		else $error("link clock period wrong");
	// the load falls on the very system edge that raises the positive link clock
	a_load_at_rise: assert property ($fell(cycle_load_n) |-> $rose(link_clk))
		else $error("load not set up at a positive rise");
	a_load_one_slot: assert property ($fell(cycle_load_n) |-> !cycle_load_n [*7] ##[1:2] cycle_load_n)
		else $error("load held for the wrong span");
	a_write_two_beats: assert property ($rose(dq_ctl_oe) |-> dq_ctl_oe [*7] ##[1:2] !dq_ctl_oe)
		else $error("write burst length wrong");
	a_one_driver: assert property (!(dq_dev_oe && dq_ctl_oe))
		else $error("both ends drive the data bus");
	a_valid_is_oe: assert property (output_valid_flag == dq_dev_oe)
		else $error("valid flag differs from device drive");
	a_read_two_beats: assert property ($rose(output_valid_flag) |-> output_valid_flag [*7] ##[1:2] !output_valid_flag)
		else $error("read burst length wrong");
	a_valid_echo: assert property ($rose(output_valid_flag) |-> ##[0:1] echo_clock_out)
		else $error("valid not aligned to echo clock");
	a_latency_two: assert property ($fell(cycle_load_n) && rd_wr && pll_disable_n
		|-> !output_valid_flag [*8] ##[9:16] $rose(output_valid_flag))
		else $error("read latency with pll on wrong");
	a_latency_one: assert property ($fell(cycle_load_n) && rd_wr && !pll_disable_n
		|-> ##[6:14] $rose(output_valid_flag))
		else $error("read latency with pll off wrong");
	a_write_no_drive: assert property ($fell(cycle_load_n) && !rd_wr |-> !dq_dev_oe [*8])
		else $error("device drives during a write");
	// ==========================================
	// covers
	c_read_on: cover property ($fell(cycle_load_n) && rd_wr && pll_disable_n);
	c_read_off: cover property ($fell(cycle_load_n) && rd_wr && !pll_disable_n);
	c_write: cover property ($rose(dq_ctl_oe));
endmodule // dbsram_properties
`default_nettype wire

// >>> test/ddr_burst_sram_bus_port_tb.sv
// Purpose: self-checking bench, controller and port joined by the link
// Assumes: memory is not reset, so every address is written first
// Notes: random bursts with random lane selects and latency mode
`timescale 1ns/1ps
`default_nettype none
module ddr_burst_sram_bus_port_tb;
	import dbsram_pkg::*;
	logic                  sys_clk, resetn, req, wr, pll_on, ready, rvalid, prev_v;
	logic [ADDR_W-1:0]     addr;
	logic [DATA_W-1:0]     wd0, wd1, rd0, rd1;
	logic [LANES-1:0]      ws0, ws1;
	logic [DATA_W-1:0]     mem0 [DEPTH];
	logic [DATA_W-1:0]     mem1 [DEPTH];
	logic [2*DATA_W-1:0]   exp_q [$];
	logic [2*DATA_W-1:0]   got;
	logic [31:0]           seed = 32'h165a6464;
	logic [31:0]           r;
	int                    num_errors = 0, n_compared = 0, i;
	dbsram_if link_if ();
	dbsram_dev u_dbsram_dev (.SYS_CLK_I(sys_clk), .RESETN_I(resetn), .LINK(link_if.dev));
	dbsram_ctl u_dbsram_ctl (.SYS_CLK_I(sys_clk), .RESETN_I(resetn), .REQ_I(req), .WRITE_I(wr), .ADDR_I(addr),
		.WDATA0_I(wd0), .WDATA1_I(wd1), .WSEL0_N_I(ws0), .WSEL1_N_I(ws1), .PLL_ON_I(pll_on), .READY_O(ready),
		.RDATA0_O(rd0), .RDATA1_O(rd1), .RVALID_O(rvalid), .LINK(link_if.ctl));
	dbsram_properties chk (.SYS_CLK_I(sys_clk), .RESETN_I(resetn), .link_clk(link_if.link_clk),
		.link_clk_n(link_if.link_clk_n), .cycle_load_n(link_if.cycle_load_n), .rd_wr(link_if.rd_wr),
		.dq_ctl_oe(link_if.dq_ctl_oe), .dq_dev_oe(link_if.dq_dev_oe), .echo_clock_out(link_if.echo_clock_out),
		.output_valid_flag(link_if.output_valid_flag), .pll_disable_n(link_if.pll_disable_n));
	// ==========================================
	// helpers
	function logic [31:0] next_rand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// lane update kept apart from the design so a shared slip cannot hide
	function automatic logic [DATA_W-1:0] put(input logic [DATA_W-1:0] o, n, input logic [LANES-1:0] s);
		for (int k = 0; k < LANES; k++) begin
			if (s[k] == 1'b0) o[k*LANE_W +: LANE_W] = n[k*LANE_W +: LANE_W];
		end
		return o;
	endfunction
	task check(input string what, input logic [DATA_W-1:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task complete_run();
		if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// request held until taken, since the controller only takes it in its slot
	task access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, d1,
		input logic [LANES-1:0] s0, s1);
		int k;
		req <= 1'b1; wr <= w; addr <= a; wd0 <= d0; wd1 <= d1; ws0 <= s0; ws1 <= s1;
		if (w) begin
			mem0[a] = put(mem0[a], d0, s0);
			mem1[a] = put(mem1[a], d1, s1);
		end else exp_q.push_back({mem1[a], mem0[a]});
		for (k = 0; k < 40 && ready !== 1'b0; k++) @(negedge sys_clk);
		@(posedge sys_clk);
		req <= 1'b0;
		for (k = 0; k < 80 && ready !== 1'b1; k++) @(negedge sys_clk);
		check("ready", DATA_W'(ready), DATA_W'(1));
		@(posedge sys_clk);
	endtask
	// ==========================================
	// result watcher
	// looked at mid-cycle, where registered outputs launched on the rising edge have settled
	always @(negedge sys_clk) begin
		if (resetn === 1'b1 && link_if.output_valid_flag === 1'b1 && prev_v !== 1'b1)
			check("dq_word0", link_if.dq, exp_q[0][DATA_W-1:0]);
		prev_v <= link_if.output_valid_flag;
		if (rvalid === 1'b1) begin
			got = exp_q.pop_front();
			check("rdata0", rd0, got[DATA_W-1:0]);
			check("rdata1", rd1, got[2*DATA_W-1:DATA_W]);
		end
	end
	// ==========================================
	// stimulus
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		#2000000;
		num_errors++;
		complete_run();
	end
	initial begin
		resetn = 1'b0; req = 1'b0; wr = 1'b0; addr = '0; wd0 = '0; wd1 = '0;
		ws0 = '1; ws1 = '1; pll_on = 1'b1; prev_v = 1'b0;
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		for (i = 0; i < DEPTH; i++) access(1'b1, ADDR_W'(i), DATA_W'(next_rand()), DATA_W'(next_rand()), '0, '0);
		for (i = 0; i < 160; i++) begin
			r = next_rand();
			pll_on <= r[0];
			access(r[1], r[2 +: ADDR_W], DATA_W'(next_rand()), DATA_W'(next_rand()), r[20 +: LANES], r[22 +: LANES]);
		end
		for (i = 0; i < 100 && exp_q.size() > 0; i++) @(posedge sys_clk);
		check("pending", DATA_W'(exp_q.size()), '0);
		complete_run();
	end
endmodule // ddr_burst_sram_bus_port_tb
`default_nettype wire
